/* File: asfb_baud.sv */
/*
 * baud generator: prescaler and power-of-two path, or 16-bit time
 * constant path with a symmetrical divide-by-2, then the sample ratio.
 * assumes one clock pclk; outputs are one-cycle enable pulses.
 */
`timescale 1ns/1ps
`include "asfb_regs.svh"

module asfb_baud
    import asfb_pkg::*;
(
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // rate configuration
    input  wire asfb_src_type src_sel,
    input  wire logic         prescale_select,
    input  wire logic [2:0]   divider_select,
    input  wire logic         sample_rate_select,
    input  wire logic [15:0]  baud_time_constant,
    // rate outputs
    output logic              sample_tick,
    output logic              bit_tick
);

    logic [4:0]  pre_cnt_reg;   // first stage counter
    logic        pre_tick;      // end of first stage
    logic [5:0]  pow_cnt_reg;   // power-of-two counter
    logic [5:0]  pow_mask;      // counter bits that must be all ones
    logic [16:0] tc_cnt_reg;    // time constant counter
    logic        half_reg;      // divide-by-2 flop for symmetry
    logic        tc_tick;       // end of one half period
    logic        src_tick;      // selected sample-rate pulse
    logic [6:0]  ratio_cnt_reg; // samples within one bit
    logic [6:0]  ratio_lim;     // 16 or 64

    // first stage divides by 10 or 30
    assign pre_tick = (pre_cnt_reg == 5'(`ASFB_PRE_BASE
                       + (prescale_select ? `ASFB_PRE_STEP : 5'h00)
                       - 5'h01));

    // code 111 kept at divide by 64 so the rate stays defined
    assign pow_mask = (divider_select > `ASFB_DIVSEL_MAX) ? 6'h3f :
                      6'((7'h01 << divider_select) - 7'h01);

    // half period tc + 2 clocks; >= lets a lowered constant act at once
    assign tc_tick = (tc_cnt_reg >= 17'({1'b0, baud_time_constant}
                      + `ASFB_TC_OFFSET - 17'h00001));

    assign ratio_lim = sample_rate_select ? `ASFB_RATIO_HIGH
                                          : `ASFB_RATIO_LOW;

    // prescaler counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pre_cnt_reg <= 5'h00;
        else if (pre_tick)
            pre_cnt_reg <= 5'h00;
        else
            pre_cnt_reg <= pre_cnt_reg + 5'h01;
    end

    // power-of-two stage advances on each prescaler pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pow_cnt_reg <= 6'h00;
        else if (pre_tick)
            pow_cnt_reg <= pow_cnt_reg + 6'h01;
    end

    // 17-bit time constant counter and its symmetry flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tc_cnt_reg <= 17'h00000;
            half_reg   <= 1'b0;
        end
        else if (tc_tick)
        begin
            tc_cnt_reg <= 17'h00000;
            half_reg   <= ~half_reg;
        end
        else
            tc_cnt_reg <= tc_cnt_reg + 17'h00001;
    end

    // source select: one pulse per sample period
    always_comb
    begin
        if (src_sel == ASFB_SRC_TC)
            src_tick = tc_tick & half_reg;
        else
            src_tick = pre_tick
                       & ((pow_cnt_reg & pow_mask) == pow_mask);
    end

    // final sample-ratio divider, same in both modes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ratio_cnt_reg <= 7'h00;
            sample_tick   <= 1'b0;
            bit_tick      <= 1'b0;
        end
        else
        begin
            sample_tick <= src_tick;
            bit_tick    <= 1'b0;
            if (src_tick)
            begin
                if (ratio_cnt_reg >= ratio_lim - 7'h01)
                begin
                    ratio_cnt_reg <= 7'h00;
                    bit_tick      <= 1'b1;
                end
                else
                    ratio_cnt_reg <= ratio_cnt_reg + 7'h01;
            end
        end
    end

endmodule

/* File: asfb_partner.sv */
/*
 * remote serial station: delivers characters and start bits, and
 * keeps the transmit shifter busy for a short or long byte time.
 * assumes pulses synchronous to pclk.
 */
`timescale 1ns/1ps

module asfb_partner
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // pace chosen by the bench
    input  wire logic slow,
    // transmit side
    input  wire logic tx_shift_load,
    output logic      tx_shift_ready,
    // receive side
    output logic       rx_char_valid,
    output logic [7:0] rx_char_data,
    output logic       rx_char_stop_bad,
    output logic       rx_start_detect
);
    logic [7:0] busy_reg; // cycles left shifting a byte

    // idle receive lines at time zero
    initial
    begin
        rx_char_valid = 1'b0;
        rx_char_data = 8'h00;
        rx_char_stop_bad = 1'b0;
        rx_start_detect = 1'b0;
    end

    // long byte time lets the holding register fill behind it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            busy_reg <= 8'h00;
        else if (tx_shift_load)
            busy_reg <= slow ? 8'h40 : 8'h02;
        else if (busy_reg != 8'h00)
            busy_reg <= busy_reg - 8'h01;
    end
    assign tx_shift_ready = (busy_reg == 8'h00);

    // start bit, then optionally the character and stop verdict
    task automatic send(input logic [7:0] d, input logic bad,
                        input logic full);
        @(posedge pclk);
        rx_start_detect <= 1'b1;
        @(posedge pclk);
        rx_start_detect <= 1'b0;
        repeat (3) @(posedge pclk);
        rx_char_valid <= full;
        rx_char_data <= d;
        rx_char_stop_bad <= bad;
        @(posedge pclk);
        // released data must not look valid
        rx_char_valid <= 1'b0;
        rx_char_data <= ~d;
        rx_char_stop_bad <= ~bad;
    endtask
endmodule

/* File: asfb_pkg.sv */
/*
 * types shared by the serial flag block and its baud generator.
 * assumes nothing beyond a systemverilog compiler.
 */
package asfb_pkg;

    // one register byte
    typedef logic [7:0] asfb_byte_type;

    // baud source choice
    typedef enum logic {ASFB_SRC_PRESCALE, ASFB_SRC_TC} asfb_src_type;

endpackage

/* File: asfb_properties.sv */
/*
 * checker for the serial flag block: apb answer, tx handoff, ticks.
 * assumes it is bound to asfb_top; one clock, async low reset.
 */
`timescale 1ns/1ps

module asfb_checker
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb slave side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // transmit handoff and rate
    input wire logic        tx_shift_ready,
    input wire logic        tx_shift_load,
    input wire logic        sample_tick
);
    // single domain, so one clock and one disable for all
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // answer only after a held access phase
    a_ready_access: assert property (pready |-> psel && penable
        && $past(psel && penable)) else $error("ready too early");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held");
    a_err_pulse: assert property (pslverr |-> pready)
        else $error("error without ready");
    // only word offsets up to the rx read register are mapped
    a_err_decode: assert property (pready |-> pslverr ==
        (paddr > 8'h1c || paddr[1:0] != 2'h0)) else $error("bad decode");
    a_reserved_zero: assert property (pready && !pwrite && !pslverr
        && paddr == 8'h00 |-> !prdata[2]) else $error("bit 2 set");
    a_load_pulse: assert property (tx_shift_load |=> !tx_shift_load)
        else $error("load held");
    a_load_cause: assert property (tx_shift_load |->
        $past(tx_shift_ready)) else $error("load while busy");
    // shortest sample period is four clocks
    a_tick_gap: assert property (sample_tick |=> !sample_tick [*3])
        else $error("ticks too close");
endmodule

bind asfb_top asfb_checker chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_shift_ready(tx_shift_ready), .tx_shift_load(tx_shift_load),
    .sample_tick(sample_tick));

/* File: asfb_regs.svh */
/*
 * register offsets, field positions, reset values and divider figures
 * for the serial flag and baud generator block.
 * assumes a 32-bit apb word per register; byte addresses below.
 */
`ifndef ASFB_REGS_SVH
`define ASFB_REGS_SVH

// register byte offsets
`define ASFB_OFF_FLAG      8'h00
`define ASFB_OFF_CTRL_A    8'h04
`define ASFB_OFF_CTRL_B    8'h08
`define ASFB_OFF_EXT       8'h0c
`define ASFB_OFF_DIV_LO    8'h10
`define ASFB_OFF_DIV_HI    8'h14
`define ASFB_OFF_TX_HOLD   8'h18
`define ASFB_OFF_RX_READ   8'h1c

// serial_flag_register fields
`define ASFB_FLAG_RX_FULL  7
`define ASFB_FLAG_STOP_ERR 4
`define ASFB_FLAG_RX_IE    3
`define ASFB_FLAG_TX_EMPTY 1
`define ASFB_FLAG_TX_IE    0

// serial_control_a field
`define ASFB_CA_ERR_CLR    3

// serial_control_b fields
`define ASFB_CB_PRESCALE   5
`define ASFB_CB_SAMPLE     3
`define ASFB_CB_DIVSEL_HI  2
`define ASFB_CB_DIVSEL_LO  0

// serial_extension_control fields
`define ASFB_EXT_SRC       3
`define ASFB_EXT_START_IRQ 2

// reset values
`define ASFB_DIV_RESET     8'hff
`define ASFB_CB_RESET      8'h00

// divider figures
`define ASFB_PRE_BASE      5'h0a
`define ASFB_PRE_STEP      5'h14
`define ASFB_RATIO_LOW     7'h10
`define ASFB_RATIO_HIGH    7'h40
`define ASFB_TC_OFFSET     17'h00002
`define ASFB_DIVSEL_MAX    3'h6

`endif

/* File: asfb_top.sv */
/*
 * serial port flag register, interrupt request, tx holding handshake,
 * receive character queue with stop-bit error tags, and registers for
 * the baud generator, all behind an apb slave.
 * assumes the receiver and transmitter shifters sit outside and talk
 * through one-cycle pulses synchronous to pclk.
 */
// Functional notes
// - bad stop bit flag rides character to read
// - error flag held until clear bit written 0
// - rx enable and rx full raise irq
// - rx enable, start-bit option, start bit raise irq
// - flag bit 2 reads 0, writes ignored
// - tx empty drops on write, returns on transfer
// - reset shows tx holding register empty
// - tx enable and tx empty raise irq
// - reset clears tx irq enable
// - tx irq needs rx enable too
// - divisor source bit picks baud path
// - prescaler divides by 10 or 30
// - divider select gives power-of-two divide
// - sample rate selects 16 or 64
// - tc path rate clock over 2(tc+2)ratio
// - rx full set on load, cleared on empty
// - tc registers reset ones, symmetric output
`timescale 1ns/1ps
`include "asfb_regs.svh"

module asfb_top
    import asfb_pkg::*;
#(
    parameter int RX_DEPTH = 4 // receive queue entries
)
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // receiver side
    input  wire logic        rx_char_valid,
    input  wire logic [7:0]  rx_char_data,
    input  wire logic        rx_char_stop_bad,
    input  wire logic        rx_start_detect,
    // transmitter side
    input  wire logic        tx_shift_ready,
    output logic             tx_shift_load,
    output logic [7:0]       tx_shift_data,
    // rate and interrupt outputs
    output logic             sample_tick,
    output logic             bit_tick,
    output logic             serial_irq_line
);

    localparam int AW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;

    // apb decode
    logic        access;      // access phase, not yet answered
    logic        done;        // completing edge of a transfer
    logic        wr_done;     // completing write
    logic        rd_done;     // completing read
    logic        mapped;      // address hits a register

    // software registers
    logic        rx_irq_enable_reg;
    logic        tx_irq_enable_reg;
    logic        error_flag_clear_reg;
    asfb_byte_type serial_control_b_reg;
    logic        divisor_source_reg;
    logic        start_bit_irq_reg;
    asfb_byte_type divisor_low_reg;
    asfb_byte_type divisor_high_reg;

    // block state
    logic        tx_empty_flag_reg;
    logic        stop_bit_error_flag_reg;
    logic        start_seen_reg;       // start bit latched for irq
    asfb_byte_type rx_read_register_reg; // head character shown
    logic        head_valid_reg;       // readable position full

    // receive queue storage and pointers
    logic [8:0]  rxq_mem [RX_DEPTH];   // {stop error, data}
    logic [AW:0] rxq_cnt_reg;
    logic [AW-1:0] rxq_wr_reg;
    logic [AW-1:0] rxq_rd_reg;
    logic        rxq_push;
    logic        rxq_pop;
    logic        tx_write;
    logic        tx_move;
    logic        irq_next;
    logic [31:0] rdata_next;

    assign access  = psel & penable & ~pready;
    assign done    = psel & penable & pready;
    assign wr_done = done & pwrite & mapped;
    assign rd_done = done & ~pwrite & mapped;

    // address decode, unmapped addresses answer with an error
    always_comb
    begin
        mapped = 1'b1;
        rdata_next = 32'h0000_0000;
        if (paddr == `ASFB_OFF_FLAG)
        begin
            rdata_next[`ASFB_FLAG_RX_FULL]  = head_valid_reg;
            rdata_next[`ASFB_FLAG_STOP_ERR] = stop_bit_error_flag_reg;
            rdata_next[`ASFB_FLAG_RX_IE]    = rx_irq_enable_reg;
            rdata_next[`ASFB_FLAG_TX_EMPTY] = tx_empty_flag_reg;
            rdata_next[`ASFB_FLAG_TX_IE]    = tx_irq_enable_reg;
            // bit 2 left at zero here
        end
        else if (paddr == `ASFB_OFF_CTRL_A)
            rdata_next[`ASFB_CA_ERR_CLR] = error_flag_clear_reg;
        else if (paddr == `ASFB_OFF_CTRL_B)
            rdata_next[7:0] = serial_control_b_reg;
        else if (paddr == `ASFB_OFF_EXT)
        begin
            rdata_next[`ASFB_EXT_SRC]       = divisor_source_reg;
            rdata_next[`ASFB_EXT_START_IRQ] = start_bit_irq_reg;
        end
        else if (paddr == `ASFB_OFF_DIV_LO)
            rdata_next[7:0] = divisor_low_reg;
        else if (paddr == `ASFB_OFF_DIV_HI)
            rdata_next[7:0] = divisor_high_reg;
        else if (paddr == `ASFB_OFF_TX_HOLD)
            rdata_next[7:0] = tx_shift_data;
        else if (paddr == `ASFB_OFF_RX_READ)
            rdata_next[7:0] = rx_read_register_reg;
        else
            mapped = 1'b0;
    end

    // apb answer: one wait state, then pready with data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= access;
            pslverr <= access & ~mapped;
            if (access & ~pwrite)
                prdata <= rdata_next;
        end
    end

    // flag register enables; bit 2 written value dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_irq_enable_reg <= 1'b0;
            tx_irq_enable_reg <= 1'b0;
        end
        else if (wr_done && paddr == `ASFB_OFF_FLAG)
        begin
            rx_irq_enable_reg <= pwdata[`ASFB_FLAG_RX_IE];
            tx_irq_enable_reg <= pwdata[`ASFB_FLAG_TX_IE];
        end
    end

    // control a: only the error clear bit lives here
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            error_flag_clear_reg <= 1'b1;
        else if (wr_done && paddr == `ASFB_OFF_CTRL_A)
            error_flag_clear_reg <= pwdata[`ASFB_CA_ERR_CLR];
    end

    // control b: prescale, sample rate and divider select
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            serial_control_b_reg <= `ASFB_CB_RESET;
        else if (wr_done && paddr == `ASFB_OFF_CTRL_B)
            serial_control_b_reg <= pwdata[7:0];
    end

    // extension: baud source and start-bit interrupt option
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            divisor_source_reg <= 1'b0;
            start_bit_irq_reg  <= 1'b0;
        end
        else if (wr_done && paddr == `ASFB_OFF_EXT)
        begin
            divisor_source_reg <= pwdata[`ASFB_EXT_SRC];
            start_bit_irq_reg  <= pwdata[`ASFB_EXT_START_IRQ];
        end
    end

    // time constant bytes, reset to all ones
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            divisor_low_reg  <= `ASFB_DIV_RESET;
            divisor_high_reg <= `ASFB_DIV_RESET;
        end
        else if (wr_done && paddr == `ASFB_OFF_DIV_LO)
            divisor_low_reg <= pwdata[7:0];
        else if (wr_done && paddr == `ASFB_OFF_DIV_HI)
            divisor_high_reg <= pwdata[7:0];
    end

    // transmit holding handshake
    // a write while not empty overwrites the pending byte; software
    // is expected to wait for the empty flag
    assign tx_write = wr_done && paddr == `ASFB_OFF_TX_HOLD;
    assign tx_move  = ~tx_empty_flag_reg & tx_shift_ready & ~tx_shift_load;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_empty_flag_reg <= 1'b1;
            tx_shift_data     <= 8'h00;
            tx_shift_load     <= 1'b0;
        end
        else
        begin
            tx_shift_load <= tx_move;
            if (tx_write)
            begin
                tx_shift_data     <= pwdata[7:0];
                tx_empty_flag_reg <= 1'b0;
            end
            else if (tx_move)
                tx_empty_flag_reg <= 1'b1;
        end
    end

    // receive queue: push from receiver, pop into readable position
    assign rxq_push = rx_char_valid && rxq_cnt_reg != (AW+1)'(RX_DEPTH);
    assign rxq_pop  = rxq_cnt_reg != '0
                      && (!head_valid_reg
                          || (rd_done && paddr == `ASFB_OFF_RX_READ));

    // queue storage; full queue drops the character
    always_ff @(posedge pclk)
    begin
        if (rxq_push)
            rxq_mem[rxq_wr_reg] <= {rx_char_stop_bad, rx_char_data};
    end

    // queue pointers and count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rxq_wr_reg  <= '0;
            rxq_rd_reg  <= '0;
            rxq_cnt_reg <= '0;
        end
        else
        begin
            if (rxq_push)
                rxq_wr_reg <= (rxq_wr_reg == AW'(RX_DEPTH - 1))
                              ? '0 : rxq_wr_reg + AW'(1);
            if (rxq_pop)
                rxq_rd_reg <= (rxq_rd_reg == AW'(RX_DEPTH - 1))
                              ? '0 : rxq_rd_reg + AW'(1);
            if (rxq_push && !rxq_pop)
                rxq_cnt_reg <= rxq_cnt_reg + (AW+1)'(1);
            else if (rxq_pop && !rxq_push)
                rxq_cnt_reg <= rxq_cnt_reg - (AW+1)'(1);
        end
    end

    // readable position and rx full flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            head_valid_reg       <= 1'b0;
            rx_read_register_reg <= 8'h00;
        end
        else if (rxq_pop)
        begin
            head_valid_reg       <= 1'b1;
            rx_read_register_reg <= rxq_mem[rxq_rd_reg][7:0];
        end
        else if (rd_done && paddr == `ASFB_OFF_RX_READ)
            head_valid_reg <= 1'b0;
    end

    // stop-bit error appears with its character; set beats clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stop_bit_error_flag_reg <= 1'b0;
        else if (rxq_pop && rxq_mem[rxq_rd_reg][8])
            stop_bit_error_flag_reg <= 1'b1;
        else if (wr_done && paddr == `ASFB_OFF_CTRL_A
                 && !pwdata[`ASFB_CA_ERR_CLR])
            stop_bit_error_flag_reg <= 1'b0;
    end

    // start bit latch, held until the option bit is written 0
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            start_seen_reg <= 1'b0;
        else if (rx_start_detect && start_bit_irq_reg)
            start_seen_reg <= 1'b1;
        else if (!start_bit_irq_reg)
            start_seen_reg <= 1'b0;
    end

    // interrupt level; tx part gated by rx enable as in silicon
    assign irq_next = (rx_irq_enable_reg & head_valid_reg)
                    | (rx_irq_enable_reg & start_bit_irq_reg
                       & (start_seen_reg | rx_start_detect))
                    | (rx_irq_enable_reg & tx_irq_enable_reg
                       & tx_empty_flag_reg);

    // registered interrupt line
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            serial_irq_line <= 1'b0;
        else
            serial_irq_line <= irq_next;
    end

    // baud generator
    asfb_baud u_baud
    (
        .pclk               (pclk),
        .presetn            (presetn),
        .src_sel            (divisor_source_reg ? ASFB_SRC_TC
                                                : ASFB_SRC_PRESCALE),
        .prescale_select    (serial_control_b_reg[`ASFB_CB_PRESCALE]),
        .divider_select     (serial_control_b_reg[`ASFB_CB_DIVSEL_HI:
                                                  `ASFB_CB_DIVSEL_LO]),
        .sample_rate_select (serial_control_b_reg[`ASFB_CB_SAMPLE]),
        .baud_time_constant ({divisor_high_reg, divisor_low_reg}),
        .sample_tick        (sample_tick),
        .bit_tick           (bit_tick)
    );

endmodule

/* File: tb.sv */
/*
 * self-checking bench for asfb_top with the remote station model.
 * assumes the checker is attached by bind; 50 MHz clock.
 */
`timescale 1ns/1ps

module tb;
    // clock, reset and apb master
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    // partner, rate and irq
    logic        slow;
    logic        rx_char_valid;
    logic [7:0]  rx_char_data;
    logic        rx_char_stop_bad;
    logic        rx_start_detect;
    logic        tx_shift_ready;
    logic        tx_shift_load;
    logic [7:0]  tx_shift_data;
    logic        sample_tick;
    logic        bit_tick;
    logic        serial_irq_line;
    // bench state
    int          mismatches;
    int          cmp_count;
    logic [7:0]  seed;
    logic [31:0] rv;
    logic        re;
    logic [4:0]  tc;
    int          n;

    asfb_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_char_valid(rx_char_valid),
        .rx_char_data(rx_char_data), .rx_char_stop_bad(rx_char_stop_bad),
        .rx_start_detect(rx_start_detect), .tx_shift_ready(tx_shift_ready),
        .tx_shift_load(tx_shift_load), .tx_shift_data(tx_shift_data),
        .sample_tick(sample_tick), .bit_tick(bit_tick),
        .serial_irq_line(serial_irq_line));

    asfb_partner partner_u (.pclk(pclk), .presetn(presetn), .slow(slow),
        .tx_shift_load(tx_shift_load), .tx_shift_ready(tx_shift_ready),
        .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
        .rx_char_stop_bad(rx_char_stop_bad),
        .rx_start_detect(rx_start_detect));

    // free-running 20 ns clock
    always #10 pclk = ~pclk;

    // 8-bit lfsr step
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // expected sample period on the prescaler path
    function automatic int pre_period(input logic ps, input int s);
        return (ps ? 30 : 10) << (s > 6 ? 6 : s);
    endfunction

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer, request held until pready
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // register read against an expected value
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rv, exp);
    endtask

    // irq is a registered level; let it settle
    task automatic irq_is(input logic exp);
        repeat (3) @(posedge pclk);
        chk({31'h0, serial_irq_line}, {31'h0, exp});
    endtask

    // cycles between two ticks of the chosen output
    task automatic per(input logic b, output int k);
        k = 0;
        do @(posedge pclk); while ((b ? bit_tick : sample_tick) !== 1'b1);
        do
        begin
            @(posedge pclk);
            k++;
        end
        while ((b ? bit_tick : sample_tick) !== 1'b1);
    endtask

    // verdict and end of run
    task automatic results();
        $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // watchdog against a hung handshake
    initial
    begin
        repeat (100000) @(posedge pclk);
        mismatches++;
        results();
    end

    // main sequence
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        slow = 1'b1;
        seed = 8'h4d;
        mismatches = 0;
        cmp_count = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 32'h02);
        rd(8'h10, 32'hff);
        rd(8'h14, 32'hff);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, re}, 32'h1);
        // status bits are read-only, bit 2 stays clear
        apb(1'b1, 8'h00, 32'hff);
        rd(8'h00, 32'h0b);
        irq_is(1'b1);
        apb(1'b1, 8'h00, 32'h01);
        irq_is(1'b0);
        // second byte waits behind a busy shifter
        apb(1'b1, 8'h00, 32'h09);
        apb(1'b1, 8'h18, 32'h5a);
        seed = lfsr(seed);
        apb(1'b1, 8'h18, {24'h0, seed});
        rd(8'h00, 32'h09);
        irq_is(1'b0);
        n = 0;
        while (tx_shift_load !== 1'b1 && n < 200)
        begin
            @(posedge pclk);
            n++;
        end
        chk({23'h0, tx_shift_load, tx_shift_data}, {23'h0, 1'b1, seed});
        rd(8'h00, 32'h0b);
        // good then bad character; error shows only at the head
        apb(1'b1, 8'h00, 32'h08);
        partner_u.send(8'h3c, 1'b0, 1'b1);
        partner_u.send(seed, 1'b1, 1'b1);
        rd(8'h00, 32'h8a);
        irq_is(1'b1);
        rd(8'h1c, 32'h3c);
        rd(8'h00, 32'h9a);
        rd(8'h1c, {24'h0, seed});
        rd(8'h00, 32'h1a);
        apb(1'b1, 8'h04, 32'h00);
        rd(8'h00, 32'h0a);
        // start bit alone raises the receive request
        apb(1'b1, 8'h0c, 32'h04);
        partner_u.send(8'h00, 1'b0, 1'b0);
        irq_is(1'b1);
        apb(1'b1, 8'h0c, 32'h00);
        irq_is(1'b0);
        // prescaler path, every divider code
        for (int s = 0; s < 8; s++)
        begin
            seed = lfsr(seed);
            apb(1'b1, 8'h08, {26'h0, seed[0], 2'b00, s[2:0]});
            per(1'b0, n);
            per(1'b0, n);
            chk(n, pre_period(seed[0], s));
        end
        // time constant path, zero first, both sample ratios
        for (int k = 0; k < 3; k++)
        begin
            seed = lfsr(seed);
            tc = (k == 0) ? 5'h00 : seed[4:0];
            apb(1'b1, 8'h10, {27'h0, tc});
            apb(1'b1, 8'h14, 32'h00);
            apb(1'b1, 8'h0c, 32'h08);
            apb(1'b1, 8'h08, {28'h0, k[0], 3'h0});
            per(1'b0, n);
            per(1'b0, n);
            chk(n, 2 * (tc + 2));
            per(1'b1, n);
            per(1'b1, n);
            chk(n, 2 * (tc + 2) * (k[0] ? 64 : 16));
        end
        results();
    end
endmodule
